// [swc_pkg.sv]
package swc_pkg;

  // register bank shape
  localparam int unsigned REG_NUM = 8;
  localparam int unsigned IDX_W   = $clog2(REG_NUM);

  // bank slots, in ascending offset order
  localparam int unsigned IDX_FAST   = 0;
  localparam int unsigned IDX_SIDE   = 1;
  localparam int unsigned IDX_ITERM  = 2;
  localparam int unsigned IDX_PLS_LO = 3;
  localparam int unsigned IDX_PLS_HI = 4;
  localparam int unsigned IDX_EQ_LO  = 5;
  localparam int unsigned IDX_EQ_HI  = 6;
  localparam int unsigned IDX_DRIVE  = 7;

  localparam logic [7:0] REG_OFS   [REG_NUM] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
  localparam logic [7:0] REG_RST   [REG_NUM] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  localparam logic [7:0] REG_WMASK [REG_NUM] = '{8'h7f, 8'h7f, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f};
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // field layout of the routing, input termination and drive registers
  localparam int unsigned EN_BIT    = 6;
  localparam int unsigned MODE_LSB  = 4;
  localparam int unsigned MODE_W    = 2;
  localparam int unsigned SRC_LSB   = 0;
  localparam int unsigned SRC_W     = 4;
  localparam int unsigned ITERM_BIT = 0;
  localparam int unsigned PE_LSB    = 2;
  localparam int unsigned PE_W      = 2;
  localparam int unsigned OTERM_BIT = 1;
  localparam int unsigned OCUR_BIT  = 0;

  localparam logic [1:0] MODE_QUAD    = 2'h0;
  localparam logic [1:0] MODE_DUAL    = 2'h1;
  localparam logic [1:0] MODE_SINGLE  = 2'h2;
  localparam logic [1:0] MODE_ILLEGAL = 2'h3;

  // serial framing
  localparam logic [3:0] I2C_BITS = 4'h8;

  // update windows: time in ns, cycles derived from the clock rate
  localparam int unsigned CLK_MHZ   = 200;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned UPD_NS [REG_NUM] = '{1000, 1000, 500, 500, 500, 500, 500, 500};

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned UPD_CYC_DEF [REG_NUM] = '{
    ns_to_cyc(UPD_NS[0]), ns_to_cyc(UPD_NS[1]), ns_to_cyc(UPD_NS[2]), ns_to_cyc(UPD_NS[3]),
    ns_to_cyc(UPD_NS[4]), ns_to_cyc(UPD_NS[5]), ns_to_cyc(UPD_NS[6]), ns_to_cyc(UPD_NS[7])};

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } swc_i2c_st_t;

endpackage

// [swc_upd_if.sv]
`timescale 1ns/1ps
interface swc_upd_if;
  logic       start;
  logic [7:0] value;
  logic [7:0] applied;
  logic       busy;
  modport unit (input start, input value, output applied, output busy);
  modport ctrl (output start, output value, input applied, input busy);
endinterface

// [swc_upd_win.sv]
`timescale 1ns/1ps
module swc_upd_win #(
  parameter int unsigned CYC     = 1,
  parameter logic [7:0]  RST_VAL = 8'h00
) (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // window port
  swc_upd_if.unit  u
);

  localparam int unsigned   CW   = (CYC > 1) ? $clog2(CYC) : 1;
  localparam logic [CW-1:0] LOAD = CW'(CYC - 1);

  if (CYC < 1) begin : g_chk
    $error("update window must last at least one cycle");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          busy_reg;
  logic          busy_next;
  logic [7:0]    applied_reg;
  logic [7:0]    applied_next;
  logic          closing;
  logic          opening;

  // a start inside an open window does not reload the count, except in its closing cycle
  assign closing      = busy_reg && (cnt_reg == '0);
  assign opening      = u.start && (!busy_reg || closing);                   // see R6 see R8
  assign busy_next    = opening || (busy_reg && !closing);
  assign cnt_next     = opening ? LOAD : (busy_reg ? cnt_reg - CW'(1) : cnt_reg);  // see R4
  // physical state takes the latest written value only when the window closes
  assign applied_next = closing ? u.value : applied_reg;                      // see R1 see R5 see R7

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg     <= '0;
      busy_reg    <= 1'b0;
      applied_reg <= RST_VAL;
    end else begin
      cnt_reg     <= cnt_next;
      busy_reg    <= busy_next;
      applied_reg <= applied_next;
    end
  end

  assign u.applied = applied_reg;
  assign u.busy    = busy_reg;

endmodule

// [swc_cfg_regs.sv]
`timescale 1ns/1ps
// Notes on behaviour
// R1 - written values reach the physical state only after an update delay, both paths
// R2 - serial write delay starts at the clock fall of the last data bit
// R3 - parallel delay starts when the changed control pin's edge is seen
// R4 - each register has its own delay length
// R5 - writes during an open window are kept but not applied yet
// R6 - writes inside a window do not restart it; the newest value wins
// R7 - at window end the most recent written values are applied
// R8 - a write after a window ended updates pending state and opens a new window
// R9 - parallel registers are loaded from the six parallel control pin groups
// R10 - pins control after reset; first serial event locks them out until reset; here only an access to this slave's own address does
// R11 - serial control starts from the serial register defaults
// R12 - low three slave address bits come from three straps; master must match
// R13 - fast routing: enable bit 6, mode bits 5:4, source bits 3:0, reset 0x40
// R14 - side routing: enable bit 6, mode bits 5:4, source bits 3:0, reset 0x40
// R15 - input termination select in bit 0, reset 0x01
// R16 - 16-bit termination pulse select, A/B low byte, C/D high byte, reset zero
// R17 - 16-bit equalization select, A/B low byte, C/D high byte, reset zero
// R18 - fast enable clear puts fast channels in standby, set turns them on
// R19 - fast mode 00 quad, 01 dual, 10 single; 11 keeps the previous mode
// R20 - side enable clear disconnects all low speed inputs, set enables switch
// R21 - drive register: preemphasis bits 3:2, termination bit 1, current bit 0, reset 0x03
// R22 - delays are parameters; unassigned bits read zero and ignore writes
module swc_cfg_regs #(
  parameter logic [3:0]  ADDR_HI = 4'h5,  // arbitrary fixed upper address bits
  parameter int unsigned UPD_CYC [swc_pkg::REG_NUM] = swc_pkg::UPD_CYC_DEF
) (
  // system
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial port
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output      logic        sda_out,
  output      logic        sda_oe_n,
  input  wire logic        addr_strap_2,
  input  wire logic        addr_strap_1,
  input  wire logic        addr_strap_0,
  // parallel control pins
  input  wire logic        pin_switch_enable,
  input  wire logic [1:0]  pin_source_select,
  input  wire logic        pin_equalize_level,
  input  wire logic [1:0]  pin_preemph_level,
  input  wire logic        pin_out_termination,
  input  wire logic        pin_out_current,
  // applied physical state
  output      logic        fast_enable,
  output      logic [1:0]  fast_mode_sel,
  output      logic [3:0]  fast_source_sel,
  output      logic        side_enable,
  output      logic [1:0]  side_mode_sel,
  output      logic [3:0]  side_source_sel,
  output      logic        input_term_sel,
  output      logic [15:0] term_pulse_sel,
  output      logic [15:0] equalize_sel,
  output      logic [1:0]  preemph_sel,
  output      logic        out_term_sel,
  output      logic        out_current_sel,
  // status
  output      logic        serial_active,
  output      logic [7:0]  update_busy
);

  localparam int unsigned N  = swc_pkg::REG_NUM;
  localparam int unsigned IW = swc_pkg::IDX_W;

  // offset to {hit, slot}
  function automatic logic [IW:0] reg_lookup(input logic [7:0] ofs);
    logic [IW:0] r;
    r = '0;
    for (int i = 0; i < N; i++) begin
      if (ofs == swc_pkg::REG_OFS[i]) begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction

  // an illegal mode code keeps the stored mode bits
  function automatic logic [7:0] keep_mode(input logic [7:0] nv, input logic [7:0] ov);
    logic [7:0] r;
    r = nv;
    if (nv[swc_pkg::MODE_LSB +: swc_pkg::MODE_W] == swc_pkg::MODE_ILLEGAL) begin
      r[swc_pkg::MODE_LSB +: swc_pkg::MODE_W] = ov[swc_pkg::MODE_LSB +: swc_pkg::MODE_W];
    end
    return r;
  endfunction

  // ---- input synchronisers
  localparam int unsigned IN_W = 13;
  logic [IN_W-1:0] sync1_reg;
  logic [IN_W-1:0] sync2_reg;
  logic            scl_s;
  logic            sda_s;
  logic [2:0]      strap_s;
  logic            pen_s;
  logic [1:0]      psel_s;
  logic            peq_s;
  logic [1:0]      ppre_s;
  logic            poto_s;
  logic            pocl_s;

  always_ff @(posedge clk) begin
    sync1_reg <= {scl_in, sda_in, addr_strap_2, addr_strap_1, addr_strap_0, pin_switch_enable,
                  pin_source_select, pin_equalize_level, pin_preemph_level, pin_out_termination,
                  pin_out_current};
    sync2_reg <= sync1_reg;
  end

  assign {scl_s, sda_s, strap_s, pen_s, psel_s, peq_s, ppre_s, poto_s, pocl_s} = sync2_reg;

  // ---- line edges and framing conditions
  logic scl_d_reg;
  logic sda_d_reg;
  logic [2:0] strap_reg;
  wire  start_ev = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  wire  stop_ev  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  wire  scl_rise = scl_s && !scl_d_reg;
  wire  scl_fall = !scl_s && scl_d_reg;

  always_ff @(posedge clk) begin
    scl_d_reg <= scl_s;
    sda_d_reg <= sda_s;
    if (!rst_n) begin
      strap_reg <= strap_s;  // see R12
    end
  end

  // ---- register bank
  logic [7:0]    ser_reg [N];
  logic [7:0]    par_val [N];
  logic [7:0]    par_prev_reg [N];
  logic [7:0]    eff [N];
  logic [7:0]    app [N];
  logic [N-1:0]  start_vec;
  logic [IW:0]   ptr_look;
  logic          ptr_hit;
  logic [IW-1:0] ptr_idx;
  logic [7:0]    rdata;
  logic [7:0]    wval;
  logic          ser_wr;
  logic          serial_reg;
  logic          boot_reg;
  logic          claim;
  logic          wr_pulse;
  logic          takeover;
  logic [7:0]    ptr_reg;
  logic [7:0]    shf_reg;

  // parallel pin images; only quad mode is reachable from the pins
  assign par_val[swc_pkg::IDX_FAST]   = {1'b0, pen_s, swc_pkg::MODE_QUAD, 2'b00, psel_s};  // see R9
  assign par_val[swc_pkg::IDX_SIDE]   = {1'b0, pen_s, swc_pkg::MODE_QUAD, 2'b00, psel_s};  // see R9
  assign par_val[swc_pkg::IDX_ITERM]  = swc_pkg::REG_RST[swc_pkg::IDX_ITERM];
  assign par_val[swc_pkg::IDX_PLS_LO] = swc_pkg::REG_RST[swc_pkg::IDX_PLS_LO];
  assign par_val[swc_pkg::IDX_PLS_HI] = swc_pkg::REG_RST[swc_pkg::IDX_PLS_HI];
  assign par_val[swc_pkg::IDX_EQ_LO]  = {8{peq_s}};                                        // see R9
  assign par_val[swc_pkg::IDX_EQ_HI]  = {8{peq_s}};                                        // see R9
  assign par_val[swc_pkg::IDX_DRIVE]  = {4'h0, ppre_s, poto_s, pocl_s};                    // see R9

  assign ptr_look = reg_lookup(ptr_reg);
  assign ptr_hit  = ptr_look[IW];
  assign ptr_idx  = ptr_look[IW-1:0];
  assign rdata    = ptr_hit ? eff[ptr_idx] : swc_pkg::RD_UNMAPPED;
  assign ser_wr   = wr_pulse && ptr_hit;                                                   // see R2
  assign takeover = claim && !serial_reg;
  assign wval     = ((ptr_idx == IW'(swc_pkg::IDX_FAST)) || (ptr_idx == IW'(swc_pkg::IDX_SIDE)))
                    ? keep_mode(shf_reg & swc_pkg::REG_WMASK[ptr_idx], ser_reg[ptr_idx])   // see R19
                    : (shf_reg & swc_pkg::REG_WMASK[ptr_idx]);                             // see R22

  for (genvar g = 0; g < N; g++) begin : g_win
    swc_upd_if ui ();
    assign eff[g] = serial_reg ? ser_reg[g] : par_val[g];                                  // see R10
    // pin edges open windows only while the pins are in control
    assign start_vec[g] = boot_reg || takeover || (ser_wr && (ptr_idx == IW'(g)))          // see R8
                          || (!serial_reg && (par_val[g] != par_prev_reg[g]));             // see R3
    assign ui.start = start_vec[g];
    assign ui.value = eff[g];
    assign app[g]   = ui.applied;
    assign update_busy[g] = ui.busy;
    swc_upd_win #(
      .CYC     (UPD_CYC[g]),
      .RST_VAL (swc_pkg::REG_RST[g])
    ) u_win (
      .clk   (clk),
      .rst_n (rst_n),
      .u     (ui)
    );
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        ser_reg[i]      <= swc_pkg::REG_RST[i];  // see R11 see R13 see R14 see R15 see R16 see R17 see R21
        par_prev_reg[i] <= swc_pkg::REG_RST[i];
      end
      serial_reg <= 1'b0;
      boot_reg   <= 1'b1;
    end else begin
      for (int i = 0; i < N; i++) begin
        par_prev_reg[i] <= par_val[i];
      end
      if (ser_wr) begin
        ser_reg[ptr_idx] <= wval;  // see R5 see R6
      end
      serial_reg <= serial_reg || claim;  // see R10
      boot_reg   <= 1'b0;
    end
  end

  // ---- serial slave
  swc_pkg::swc_i2c_st_t st_reg;
  swc_pkg::swc_i2c_st_t st_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] shf_next;
  logic [7:0] ptr_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic       rw_reg;
  logic       rw_next;
  logic       oen_reg;
  logic       oen_next;
  logic       mack_reg;
  logic       mack_next;
  wire  [6:0] my_addr = {ADDR_HI, strap_reg};  // see R12
  wire        last_bit = (cnt_reg == swc_pkg::I2C_BITS);

  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    shf_next  = shf_reg;
    ptr_next  = ptr_reg;
    tx_next   = tx_reg;
    rw_next   = rw_reg;
    oen_next  = oen_reg;
    mack_next = mack_reg;
    wr_pulse  = 1'b0;
    claim     = 1'b0;
    if (stop_ev) begin
      st_next  = swc_pkg::ST_IDLE;
      oen_next = 1'b1;
    end else if (start_ev) begin
      st_next  = swc_pkg::ST_ADDR;
      cnt_next = '0;
      oen_next = 1'b1;
    end else if (scl_rise) begin
      if (st_reg inside {swc_pkg::ST_ADDR, swc_pkg::ST_REG, swc_pkg::ST_WDATA, swc_pkg::ST_RDATA}) begin
        shf_next = {shf_reg[6:0], sda_s};
        cnt_next = cnt_reg + 4'h1;
      end
      if (st_reg == swc_pkg::ST_RDATA_ACK) begin
        mack_next = !sda_s;
      end
    end else if (scl_fall) begin
      unique case (st_reg)
        swc_pkg::ST_IDLE: begin
        end
        swc_pkg::ST_ADDR: if (last_bit) begin
          if (shf_reg[7:1] == my_addr) begin
            st_next  = swc_pkg::ST_ADDR_ACK;
            oen_next = 1'b0;
            rw_next  = shf_reg[0];
            claim    = 1'b1;  // see R10
          end else begin
            st_next = swc_pkg::ST_IDLE;
          end
        end
        swc_pkg::ST_ADDR_ACK: begin
          cnt_next = '0;
          if (rw_reg) begin
            st_next  = swc_pkg::ST_RDATA;
            tx_next  = rdata;
            oen_next = rdata[7];
          end else begin
            st_next  = swc_pkg::ST_REG;
            oen_next = 1'b1;
          end
        end
        swc_pkg::ST_REG: if (last_bit) begin
          ptr_next = shf_reg;
          st_next  = swc_pkg::ST_REG_ACK;
          oen_next = 1'b0;
        end
        swc_pkg::ST_REG_ACK: begin
          st_next  = swc_pkg::ST_WDATA;
          cnt_next = '0;
          oen_next = 1'b1;
        end
        swc_pkg::ST_WDATA: if (last_bit) begin
          wr_pulse = 1'b1;  // see R2
          st_next  = swc_pkg::ST_WDATA_ACK;
          oen_next = 1'b0;
        end
        swc_pkg::ST_WDATA_ACK: begin
          ptr_next = ptr_reg + 8'h01;
          st_next  = swc_pkg::ST_WDATA;
          cnt_next = '0;
          oen_next = 1'b1;
        end
        swc_pkg::ST_RDATA: begin
          if (last_bit) begin
            ptr_next = ptr_reg + 8'h01;
            st_next  = swc_pkg::ST_RDATA_ACK;
            oen_next = 1'b1;
          end else begin
            tx_next  = {tx_reg[6:0], 1'b0};
            oen_next = tx_reg[6];
          end
        end
        swc_pkg::ST_RDATA_ACK: begin
          cnt_next = '0;
          if (mack_reg) begin
            st_next  = swc_pkg::ST_RDATA;
            tx_next  = rdata;
            oen_next = rdata[7];
          end else begin
            st_next = swc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg   <= swc_pkg::ST_IDLE;
      cnt_reg  <= '0;
      shf_reg  <= '0;
      ptr_reg  <= '0;
      tx_reg   <= '0;
      rw_reg   <= 1'b0;
      oen_reg  <= 1'b1;
      mack_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      shf_reg  <= shf_next;
      ptr_reg  <= ptr_next;
      tx_reg   <= tx_next;
      rw_reg   <= rw_next;
      oen_reg  <= oen_next;
      mack_reg <= mack_next;
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = oen_reg;

  // ---- applied state fan-out
  assign fast_enable     = app[swc_pkg::IDX_FAST][swc_pkg::EN_BIT];                      // see R18
  assign fast_mode_sel   = app[swc_pkg::IDX_FAST][swc_pkg::MODE_LSB +: swc_pkg::MODE_W];
  assign fast_source_sel = app[swc_pkg::IDX_FAST][swc_pkg::SRC_LSB +: swc_pkg::SRC_W];
  assign side_enable     = app[swc_pkg::IDX_SIDE][swc_pkg::EN_BIT];                      // see R20
  assign side_mode_sel   = app[swc_pkg::IDX_SIDE][swc_pkg::MODE_LSB +: swc_pkg::MODE_W];
  assign side_source_sel = app[swc_pkg::IDX_SIDE][swc_pkg::SRC_LSB +: swc_pkg::SRC_W];
  assign input_term_sel  = app[swc_pkg::IDX_ITERM][swc_pkg::ITERM_BIT];
  assign term_pulse_sel  = {app[swc_pkg::IDX_PLS_HI], app[swc_pkg::IDX_PLS_LO]};
  assign equalize_sel    = {app[swc_pkg::IDX_EQ_HI], app[swc_pkg::IDX_EQ_LO]};
  assign preemph_sel     = app[swc_pkg::IDX_DRIVE][swc_pkg::PE_LSB +: swc_pkg::PE_W];
  assign out_term_sel    = app[swc_pkg::IDX_DRIVE][swc_pkg::OTERM_BIT];
  assign out_current_sel = app[swc_pkg::IDX_DRIVE][swc_pkg::OCUR_BIT];
  assign serial_active   = serial_reg;

endmodule

// [swc_cfg_regs_asserts.sv]
`timescale 1ns/1ps
module swc_cfg_regs_asserts #(
  parameter int unsigned UPD_CYC [swc_pkg::REG_NUM] = swc_pkg::UPD_CYC_DEF
) (
  // system
  input wire logic        clk,
  input wire logic        rst_n,
  // serial pin
  input wire logic        scl_in,
  input wire logic        sda_oe_n,
  // applied state
  input wire logic        fast_enable,
  input wire logic [1:0]  fast_mode_sel,
  input wire logic [3:0]  fast_source_sel,
  input wire logic [1:0]  side_mode_sel,
  input wire logic [15:0] equalize_sel,
  input wire logic [1:0]  preemph_sel,
  input wire logic        out_term_sel,
  input wire logic        out_current_sel,
  // status
  input wire logic        serial_active,
  input wire logic [7:0]  update_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  for (genvar i = 0; i < 8; i++) begin : g_win
    // cycles this window has stayed open; busy stands for exactly UPD_CYC cycles
    logic [9:0] open_cnt;
    always_ff @(posedge clk) begin
      if (!rst_n || !update_busy[i]) begin
        open_cnt <= 10'h000;
      end else begin
        open_cnt <= open_cnt + 10'h001;
      end
    end
    a_window_len: assert property ($fell(update_busy[i]) |-> open_cnt == UPD_CYC[i])
      else $error("window length wrong");
  end
  a_fast_hold: assert property (update_busy[0] && $past(update_busy[0])
    |-> $stable({fast_enable, fast_mode_sel, fast_source_sel})) else $error("route moved inside window");
  a_eq_change: assert property (!$stable(equalize_sel[7:0]) |-> $fell(update_busy[5]))
    else $error("equalizer moved outside window end");
  a_drive_change: assert property (!$stable({preemph_sel, out_term_sel, out_current_sel})
    |-> $fell(update_busy[7])) else $error("drive moved outside window end");
  a_serial_sticky: assert property (serial_active |=> serial_active)
    else $error("serial control dropped");
  a_reset_defaults: assert property ($rose(rst_n) |-> {fast_enable, fast_mode_sel, fast_source_sel} == 7'h40
    && update_busy == 8'h00 && !serial_active && sda_oe_n) else $error("state after reset wrong");
  a_boot_windows: assert property ($rose(rst_n) |-> ##[1:3] update_busy == 8'hff)
    else $error("boot windows not opened");
  a_ack_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
  a_mode_legal: assert property (fast_mode_sel != swc_pkg::MODE_ILLEGAL && side_mode_sel != swc_pkg::MODE_ILLEGAL)
    else $error("illegal mode applied");
endmodule
bind swc_cfg_regs swc_cfg_regs_asserts #(.UPD_CYC(UPD_CYC)) swc_cfg_regs_asserts_inst (.*);

// [swc_i2c_master.sv]
`timescale 1ns/1ps
module swc_i2c_master (
  // serial pins
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_w
);
  // both lines idle high; sda_drv low pulls the wire down
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // one clock period; driving 1 releases the line so the slave can answer
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    #12 scl = 1'b1;
    #12 s = sda_w;
    #12 scl = 1'b0;
    #12;
  endtask
  // start when stp is 0, stop when 1
  task automatic cond(input logic stp);
    sda_drv = !stp;
    #12 scl = 1'b1;
    #24 sda_drv = stp;
    #24 scl = stp;
    #12;
  endtask
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(v[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    cond(1'b0);
    put_byte({dev, 1'b0}, a0);
    put_byte(ofs, a1);
    put_byte(d, a2);
    cond(1'b1);
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    cond(1'b0);
    put_byte({dev, 1'b0}, a);
    put_byte(ofs, a);
    cond(1'b0);
    put_byte({dev, 1'b1}, a);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, a);
    cond(1'b1);
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned CYC [swc_pkg::REG_NUM] = '{12, 10, 8, 6, 6, 400, 6, 6};
  // arbitrary upper address bits 4'h6, straps 3'b101
  localparam logic [6:0] DEV = 7'h35;
  localparam logic [7:0] VAL [8] = '{8'ha7, 8'h96, 8'hff, 8'h5a, 8'hc3, 8'h81, 8'h7e, 8'hfe};
  localparam logic [7:0] PAR [8] = '{8'h42, 8'h42, 8'h01, 8'h00, 8'h00, 8'hff, 8'hff, 8'h04};
  logic        clk, rst_n, scl_in, sda_drv, sda_out, sda_oe_n, ok, serial_active;
  logic        addr_strap_2, addr_strap_1, addr_strap_0;
  logic        pin_switch_enable, pin_equalize_level, pin_out_termination, pin_out_current;
  logic        fast_enable, side_enable, input_term_sel, out_term_sel, out_current_sel;
  logic [1:0]  pin_source_select, pin_preemph_level, fast_mode_sel, side_mode_sel, preemph_sel;
  logic [3:0]  fast_source_sel, side_source_sel;
  logic [7:0]  update_busy, rdat;
  logic [15:0] term_pulse_sel, equalize_sel;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  wire         sda_w = sda_drv & (sda_oe_n | sda_out);

  swc_cfg_regs #(.ADDR_HI(4'h6), .UPD_CYC(CYC)) swc_cfg_regs_inst (.*, .sda_in(sda_w));
  swc_i2c_master swc_i2c_master_inst (.scl(scl_in), .sda_drv(sda_drv), .sda_w(sda_w));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // applied state of one register slot, packed as its register image
  function automatic logic [7:0] app(input int i);
    case (i)
      0: return {1'b0, fast_enable, fast_mode_sel, fast_source_sel};
      1: return {1'b0, side_enable, side_mode_sel, side_source_sel};
      2: return {7'h00, input_term_sel};
      3: return term_pulse_sel[7:0];
      4: return term_pulse_sel[15:8];
      5: return equalize_sel[7:0];
      6: return equalize_sel[15:8];
      default: return {4'h0, preemph_sel, out_term_sel, out_current_sel};
    endcase
  endfunction
  task automatic idle();
    for (int n = 0; n < 1000; n++) begin
      @(negedge clk);
      if (update_busy === 8'h00) return;
    end
    chk("idle", update_busy, 8'h00);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    {addr_strap_2, addr_strap_1, addr_strap_0} = 3'b101;
    {pin_switch_enable, pin_source_select, pin_equalize_level} = 4'b1101;
    {pin_preemph_level, pin_out_termination, pin_out_current} = 4'b0100;
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < 8; i++) chk("reset", app(i), swc_pkg::REG_RST[i]);
    @(posedge clk) rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    idle();
    for (int i = 0; i < 8; i++) chk("pin image", app(i), PAR[i]);
    @(posedge clk) pin_out_current <= 1'b1;
    repeat (5) @(negedge clk);
    chk("pin window", {7'h00, update_busy[7]}, 8'h01);
    chk("pin early", app(7), 8'h04);
    idle();
    chk("pin late", app(7), 8'h05);
    swc_i2c_master_inst.wr(DEV ^ 7'h01, 8'h00, 8'h00, ok);
    chk("foreign ack", {7'h00, ok}, 8'h00);
    chk("still parallel", {7'h00, serial_active}, 8'h00);
    swc_i2c_master_inst.wr(DEV, 8'h00, 8'h5b, ok);
    chk("own ack", {7'h00, ok}, 8'h01);
    chk("takeover", {7'h00, serial_active}, 8'h01);
    chk("route", app(0), 8'h5b);
    idle();
    for (int i = 1; i < 8; i++) chk("serial default", app(i), swc_pkg::REG_RST[i]);
    @(posedge clk) {pin_switch_enable, pin_source_select, pin_equalize_level, pin_preemph_level} <= 6'b011010;
    pin_out_termination <= 1'b1;
    repeat (20) @(negedge clk);
    chk("pins ignored", update_busy, 8'h00);
    chk("pins route", app(0), 8'h5b);
    for (int i = 0; i < 8; i++) begin
      swc_i2c_master_inst.wr(DEV, swc_pkg::REG_OFS[i], VAL[i], ok);
      swc_i2c_master_inst.rd(DEV, swc_pkg::REG_OFS[i], rdat);
      chk("read back", rdat, VAL[i] & swc_pkg::REG_WMASK[i]);
      idle();
      chk("applied", app(i), VAL[i] & swc_pkg::REG_WMASK[i]);
    end
    for (int i = 0; i < 2; i++) begin
      swc_i2c_master_inst.wr(DEV, swc_pkg::REG_OFS[i], 8'h7c, ok);
      idle();
      chk("illegal mode", app(i), {2'b01, VAL[i][5:4], 4'hc});
    end
    swc_i2c_master_inst.wr(DEV, 8'h05, 8'hff, ok);
    swc_i2c_master_inst.rd(DEV, 8'h05, rdat);
    chk("unmapped", rdat, 8'h00);
    swc_i2c_master_inst.wr(DEV, 8'h13, 8'h11, ok);
    chk("open window", {7'h00, update_busy[5]}, 8'h01);
    swc_i2c_master_inst.wr(DEV, 8'h13, 8'h22, ok);
    chk("held", app(5), 8'h81);
    repeat (200) @(negedge clk);
    chk("no restart", app(5), 8'h22);
    swc_i2c_master_inst.wr(DEV, 8'h13, 8'h33, ok);
    chk("new window", {7'h00, update_busy[5]}, 8'h01);
    chk("pending", app(5), 8'h22);
    idle();
    chk("after window", app(5), 8'h33);
    close_out();
  end
endmodule
